// *** src/smlc_lock_ctrl.sv ***
`timescale 1ns/1ps
module smlc_lock_ctrl (
  input  wire logic                     core_clk,       // 40 MHz clock
  input  wire logic                     reset_n,        // Asynchronous reset
  input  wire logic                     spi_sen,        // Serial enable pin, high in frame
  input  wire logic                     spi_sck,        // Serial clock pin
  input  wire logic                     spi_sdi,        // Serial data in pin
  output logic                          spi_sdo,        // Serial data out
  output logic                          spi_sdo_oe,     // High while driving serial data out
  output logic                          vco_sen,        // Subsystem transfer enable
  output logic                          vco_sclk,       // Subsystem transfer clock
  output logic                          vco_sdat,       // Subsystem transfer data, MSB first
  output logic                          vco_xfer_done,  // Pulse at end of a transfer
  input  wire logic                     cal_valid,      // Calibration data strobe
  input  wire logic [8:0]               cal_data,       // Calibration data value
  input  wire logic                     int_write_evt,  // Integer frequency written
  input  wire logic                     frac_write_evt, // Fractional frequency written
  output logic                          cal_start,      // Pulse starting auto calibration
  output logic                          seed_load,      // Pulse loading modulator seed
  output logic [23:0]                   modulator_seed, // Seed value for the modulator
  output smlc_pkg::smlc_mod_ctrl_s      mod_ctrl,       // Modulator controls
  input  wire logic                     ld_sample,      // One divided-VCO count compared
  input  wire logic                     ld_inside,      // That count fell in the window
  output logic                          ld_locked,      // Lock declared
  output logic                          relock_req,     // Pulse requesting one relock
  output smlc_pkg::smlc_ld_ctrl_s       ld_ctrl         // Lock window timer controls
);
  import smlc_pkg::*;
  typedef enum logic {XF_IDLE, XF_SHIFT} smlc_xf_e;
  logic        sen_s1, sen_s2, sck_s1, sck_s2, sck_q, sdi_s1, sdi_s2;
  logic [4:0]  bit_cnt;
  logic [29:0] in_sh;
  logic [23:0] out_sh;
  logic        rd_active;
  logic        sck_rise, sck_fall, wr_stb, rd_load;
  logic [5:0]  wr_addr, rd_addr;
  logic [23:0] wr_data, rd_data;
  logic [15:0] vco_port;
  logic [23:0] mod_cfg, ld_cfg;
  logic        xf_pend, xf_phase, wr_vco, relock_tried;
  logic [3:0]  xf_cnt;
  logic [15:0] xf_sh, ld_cnt, ld_target;
  smlc_xf_e    xf_state;

  // Pins pass two flops before use; sck_q only delays the settled copy.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {sen_s1, sen_s2, sck_s1, sck_s2, sck_q, sdi_s1, sdi_s2} <= 7'h00;
    end else begin
      {sen_s1, sck_s1, sdi_s1} <= {spi_sen, spi_sck, spi_sdi};
      {sen_s2, sck_s2, sdi_s2} <= {sen_s1, sck_s1, sdi_s1};
      sck_q <= sck_s2;
    end
  end

  assign sck_rise = sen_s2 & sck_s2 & ~sck_q;
  assign sck_fall = sen_s2 & ~sck_s2 & sck_q;
  assign wr_stb   = sck_rise && bit_cnt == SPI_LAST_BIT && !in_sh[29];
  assign wr_addr  = in_sh[28:23];
  assign wr_data  = {in_sh[22:0], sdi_s2};
  assign rd_load  = sck_rise && bit_cnt == SPI_HDR_LAST && in_sh[5];
  assign rd_addr  = {in_sh[4:0], sdi_s2};
  assign wr_vco   = wr_stb && wr_addr == ADDR_VCO;

  always_comb begin
    unique case (rd_addr)
      ADDR_VCO: rd_data = {8'h00, vco_port};
      ADDR_MOD: rd_data = mod_cfg;
      ADDR_LD:  rd_data = ld_cfg;
      default:  rd_data = 24'h000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt   <= 5'h00;
      in_sh     <= 30'h00000000;
      out_sh    <= 24'h000000;
      rd_active <= 1'b0;
    end else if (!sen_s2) begin
      bit_cnt   <= 5'h00;
      rd_active <= 1'b0;
    end else if (sck_rise) begin
      in_sh   <= {in_sh[28:0], sdi_s2};
      bit_cnt <= bit_cnt + 5'h01;
      if (rd_load) begin
        out_sh    <= rd_data;
        rd_active <= 1'b1;
      end
    end else if (sck_fall && rd_active && bit_cnt > SPI_HDR_LAST + 5'h01) begin
      out_sh <= {out_sh[22:0], 1'b0};
    end
  end

  assign spi_sdo    = out_sh[23];
  assign spi_sdo_oe = sen_s2 & rd_active;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vco_port <= RST_VCO;
      mod_cfg  <= RST_MOD;
      ld_cfg   <= RST_LD;
    end else begin
      if (wr_vco) begin
        vco_port <= wr_data[VCO_WORD_W-1:0];
      end else if (cal_valid) begin
        vco_port[15:7] <= cal_data;
      end
      if (wr_stb && wr_addr == ADDR_MOD) begin
        mod_cfg <= wr_data;
      end
      if (wr_stb && wr_addr == ADDR_LD) begin
        ld_cfg <= wr_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      xf_state      <= XF_IDLE;
      xf_pend       <= 1'b0;
      xf_phase      <= 1'b0;
      xf_cnt        <= 4'h0;
      xf_sh         <= 16'h0000;
      vco_xfer_done <= 1'b0;
    end else begin
      vco_xfer_done <= 1'b0;
      unique case (xf_state)
        XF_IDLE: begin
          xf_pend <= wr_vco | cal_valid;
          if (xf_pend) begin
            xf_state <= XF_SHIFT;
            xf_sh    <= vco_port;
            xf_cnt   <= 4'h0;
            xf_phase <= 1'b0;
          end
        end
        XF_SHIFT: begin
          xf_pend  <= xf_pend | wr_vco | cal_valid;
          xf_phase <= ~xf_phase;
          if (xf_phase) begin
            xf_sh  <= {xf_sh[14:0], 1'b0};
            xf_cnt <= xf_cnt + 4'h1;
            if (xf_cnt == VCO_LAST_BIT) begin
              xf_state      <= XF_IDLE;
              vco_xfer_done <= 1'b1;
            end
          end
        end
      endcase
    end
  end
  assign vco_sen  = xf_state == XF_SHIFT;
  assign vco_sclk = xf_phase;
  assign vco_sdat = xf_sh[15];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seed_load      <= 1'b0;
      modulator_seed <= SEED_A;
      cal_start      <= 1'b0;
    end else begin
      cal_start <= mod_cfg[MOD_CORE_EN] ? frac_write_evt : int_write_evt;
      seed_load <= frac_write_evt & mod_cfg[MOD_RELOAD_SEED_ON_FREQ_WRITE];
      if (frac_write_evt && mod_cfg[MOD_RELOAD_SEED_ON_FREQ_WRITE]) begin
        unique case (mod_cfg[MOD_SEED_LSB +: 2])
          2'h0: modulator_seed <= SEED_ZERO;
          2'h1: modulator_seed <= SEED_LSB;
          2'h2: modulator_seed <= SEED_A;
          2'h3: modulator_seed <= SEED_B;
        endcase
      end
    end
  end

  always_comb begin
    mod_ctrl.order       = smlc_order_e'(mod_cfg[MOD_ORD_LSB +: 2]);
    mod_ctrl.bypass      = mod_cfg[MOD_BYPASS];
    mod_ctrl.core_enable = mod_cfg[MOD_CORE_EN];
    if (mod_cfg[MOD_CLK_DLY]) begin
      mod_ctrl.clk_src = SRC_VCO_DLY;
    end else if (mod_cfg[MOD_AUTO_CLK]) begin
      mod_ctrl.clk_src = SRC_AUX;
    end else begin
      mod_ctrl.clk_src = mod_cfg[MOD_SRC_VCO] ? SRC_VCO_DIV : SRC_REF_DIV;
    end
    mod_ctrl.bist_enable = mod_cfg[MOD_BIST_EN];
    unique case (mod_cfg[MOD_BIST_LSB +: 2])
      2'h0: mod_ctrl.bist_cycles = BIST_C0;
      2'h1: mod_ctrl.bist_cycles = BIST_C1;
      2'h2: mod_ctrl.bist_cycles = BIST_C2;
      2'h3: mod_ctrl.bist_cycles = BIST_C3;
    endcase
    // window type and duration in half cycles
    ld_ctrl.window_digital = ld_cfg[LD_WIN_DIG];
    if (ld_cfg[LD_WIN_DIG]) begin
      ld_ctrl.window_half_cycles = 8'h01 << ld_cfg[LD_DUR_LSB +: 3];
    end else begin
      ld_ctrl.window_half_cycles = 8'(2 * ANALOG_WIN_CYC);
    end
    ld_ctrl.timer_speed      = ld_cfg[LD_FREQ_LSB +: 2];
    ld_ctrl.timer_continuous = ld_cfg[LD_TEST];
    unique case (ld_cfg[LD_CNT_LSB +: 3])
      3'h0: ld_target = 16'h0005;
      3'h1: ld_target = 16'h0020;
      3'h2: ld_target = 16'h0060;
      3'h3: ld_target = 16'h0100;
      3'h4: ld_target = 16'h0200;
      3'h5: ld_target = 16'h0800;
      3'h6: ld_target = 16'h2000;
      3'h7: ld_target = 16'hFFFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ld_cnt       <= 16'h0000;
      ld_locked    <= 1'b0;
      relock_req   <= 1'b0;
      relock_tried <= 1'b0;
    end else begin
      relock_req <= 1'b0;
      if (!ld_cfg[LD_EN]) begin
        ld_cnt    <= 16'h0000;
        ld_locked <= 1'b0;
      end else if (ld_sample && ld_inside) begin
        if ({1'b0, ld_cnt} + 17'h00001 >= {1'b0, ld_target}) begin
          ld_locked    <= 1'b1;
          relock_tried <= 1'b0;
        end else begin
          ld_cnt <= ld_cnt + 16'h0001;
        end
      end else if (ld_sample) begin
        ld_cnt    <= 16'h0000;
        ld_locked <= 1'b0;
        if (ld_locked && ld_cfg[LD_RELOCK] && !relock_tried) begin
          relock_req   <= 1'b1;
          relock_tried <= 1'b1;
        end
      end
    end
  end

  property p_port_layout;
    @(posedge core_clk) disable iff (!reset_n)
      wr_vco |=> vco_port == $past(wr_data[15:0]);
  endproperty
  a_port_layout: assert property (p_port_layout) else $error("port word not stored");
  property p_xfer_start;
    @(posedge core_clk) disable iff (!reset_n)
      wr_vco && xf_state == XF_IDLE |-> ##[1:3] vco_sen;
  endproperty
  a_xfer_start: assert property (p_xfer_start) else $error("transfer not started");
  property p_readback;
    @(posedge core_clk) disable iff (!reset_n)
      rd_load && rd_addr == ADDR_VCO |=> out_sh == {8'h00, $past(vco_port)};
  endproperty
  a_readback: assert property (p_readback) else $error("port readback wrong");
  property p_seed_b;
    @(posedge core_clk) disable iff (!reset_n)
      frac_write_evt && mod_cfg[MOD_RELOAD_SEED_ON_FREQ_WRITE] && mod_cfg[1:0] == 2'h3
      |=> seed_load && modulator_seed == SEED_B;
  endproperty
  a_seed_b: assert property (p_seed_b) else $error("seed constant wrong");
  property p_no_reload;
    @(posedge core_clk) disable iff (!reset_n)
      !mod_cfg[MOD_RELOAD_SEED_ON_FREQ_WRITE] |=> !seed_load && $stable(modulator_seed);
  endproperty
  a_no_reload: assert property (p_no_reload) else $error("seed reloaded while off");
  property p_cal_frac;
    @(posedge core_clk) disable iff (!reset_n)
      frac_write_evt && !int_write_evt && mod_cfg[MOD_CORE_EN] |=> cal_start;
  endproperty
  a_cal_frac: assert property (p_cal_frac) else $error("calibration not started");
  property p_ld_off;
    @(posedge core_clk) disable iff (!reset_n)
      !ld_cfg[LD_EN] |=> !ld_locked && ld_cnt == 16'h0000;
  endproperty
  a_ld_off: assert property (p_ld_off) else $error("lock while disabled");
  property p_relock_once;
    @(posedge core_clk) disable iff (!reset_n)
      relock_req |=> !relock_req && relock_tried;
  endproperty
  a_relock_once: assert property (p_relock_once) else $error("relock repeated");
  property p_cal_fields;
    @(posedge core_clk) disable iff (!reset_n)
      cal_valid && !wr_vco |=> vco_port[6:0] == $past(vco_port[6:0])
        && vco_port[15:7] == $past(cal_data);
  endproperty
  a_cal_fields: assert property (p_cal_fields) else $error("calibration touched id");
  property p_clk_dly;
    @(posedge core_clk) disable iff (!reset_n)
      mod_cfg[MOD_CLK_DLY] |-> mod_ctrl.clk_src == SRC_VCO_DLY;
  endproperty
  a_clk_dly: assert property (p_clk_dly) else $error("clock select ignored");
endmodule : smlc_lock_ctrl

// *** src/smlc_pkg.sv ***
package smlc_pkg;
  // Serial control frame: read flag, 6-bit address, 24-bit data, MSB first.
  localparam int           SPI_ADDR_W   = 6;
  localparam int           SPI_DATA_W   = 24;
  localparam logic [4:0]   SPI_HDR_LAST = 5'h06;
  localparam logic [4:0]   SPI_LAST_BIT = 5'h1E;
  localparam logic [5:0]   ADDR_VCO     = 6'h05;
  localparam logic [5:0]   ADDR_MOD     = 6'h06;
  localparam logic [5:0]   ADDR_LD      = 6'h07;
  localparam logic [15:0]  RST_VCO      = 16'h0000;
  localparam logic [23:0]  RST_MOD      = 24'h200B4A;
  localparam logic [23:0]  RST_LD       = 24'h00014D;
  // Modulator configuration fields.
  localparam int           MOD_SEED_LSB = 0;
  localparam int           MOD_ORD_LSB  = 2;
  localparam int           MOD_BYPASS   = 7;
  localparam int           MOD_RELOAD_SEED_ON_FREQ_WRITE = 8;
  localparam int           MOD_SRC_VCO  = 9;
  localparam int           MOD_CLK_DLY  = 10;
  localparam int           MOD_CORE_EN  = 11;
  localparam int           MOD_BIST_EN  = 18;
  localparam int           MOD_BIST_LSB = 19;
  localparam int           MOD_AUTO_CLK = 21;
  localparam logic [23:0]  SEED_ZERO    = 24'h000000;
  localparam logic [23:0]  SEED_LSB     = 24'h000001;
  localparam logic [23:0]  SEED_A       = 24'hB29D08;
  localparam logic [23:0]  SEED_B       = 24'h50F1CD;
  localparam logic [12:0]  BIST_C0      = 13'h0408;
  localparam logic [12:0]  BIST_C1      = 13'h07FF;
  localparam logic [12:0]  BIST_C2      = 13'h0BFF;
  localparam logic [12:0]  BIST_C3      = 13'h0FFF;
  // Lock detect configuration fields.
  localparam int           LD_CNT_LSB   = 0;
  localparam int           LD_EN        = 3;
  localparam int           LD_WIN_DIG   = 6;
  localparam int           LD_DUR_LSB   = 7;
  localparam int           LD_FREQ_LSB  = 10;
  localparam int           LD_TEST      = 12;
  localparam int           LD_RELOCK    = 13;
  localparam int           CLK_PERIOD_NS    = 25;
  localparam int           ANALOG_WIN_NS    = 10;
  localparam int           ANALOG_WIN_CYC   = (ANALOG_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int           VCO_WORD_W   = 16;
  localparam logic [3:0]   VCO_LAST_BIT = 4'hF;

  typedef enum logic [1:0] {ORD_FIRST, ORD_SECOND, ORD_T1_B, ORD_T2_A} smlc_order_e;
  typedef enum logic [1:0] {SRC_REF_DIV, SRC_VCO_DIV, SRC_AUX, SRC_VCO_DLY} smlc_clk_src_e;

  typedef struct packed {
    smlc_order_e   order;
    logic          bypass;
    logic          core_enable;
    smlc_clk_src_e clk_src;
    logic          bist_enable;
    logic [12:0]   bist_cycles;
  } smlc_mod_ctrl_s;

  typedef struct packed {
    logic          window_digital;
    logic [7:0]    window_half_cycles;
    logic [1:0]    timer_speed;
    logic          timer_continuous;
  } smlc_ld_ctrl_s;
endpackage : smlc_pkg

// *** tb/smlc_host.sv ***
`timescale 1ns/1ps
module smlc_host (
  input  wire logic core_clk,   // System clock
  output logic      spi_sen,    // Frame enable
  output logic      spi_sck,    // Serial clock
  output logic      spi_sdi,    // Serial data to the device
  input  wire logic spi_sdo,    // Serial data from the device
  input  wire logic spi_sdo_oe  // Device drives read data
);
  initial begin
    spi_sen = 1'b0;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
  end

  // Sends read flag, address and data MSB first; hc sets each clock phase.
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [23:0] wd,
                      input int hc, output logic [23:0] rdv);
    logic [30:0] f;
    f = {rd, a, wd};
    rdv = 24'h000000;
    for (int i = 0; i < 31; i++) begin
      @(posedge core_clk);
      spi_sen <= 1'b1;
      spi_sck <= 1'b0;
      spi_sdi <= f[30-i];
      repeat (hc) @(posedge core_clk);
      spi_sck <= 1'b1;
      @(posedge core_clk);
      if (i > 6) rdv[30-i] = spi_sdo_oe ? spi_sdo : 1'bx;
      repeat (hc - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    spi_sen <= 1'b0;
    spi_sck <= 1'b0;
    // The released data line must not keep showing the last bit.
    spi_sdi <= ~spi_sdi;
    repeat (hc + 2) @(posedge core_clk);
  endtask : xfer
endmodule : smlc_host

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import smlc_pkg::*;
  logic           core_clk, reset_n, spi_sen, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe;
  logic           vco_sen, vco_sclk, vco_sdat, vco_xfer_done, cal_valid;
  logic           int_write_evt, frac_write_evt, cal_start, seed_load;
  logic           ld_sample, ld_inside, ld_locked, relock_req, sclk_q;
  logic [8:0]     cal_data;
  logic [15:0]    v, sh;
  logic [23:0]    modulator_seed, rd, d, dv;
  logic [23:0]    q_x[$], q_s[$], q_c[$], q_r[$];
  logic [23:0]    seeds [4] = '{SEED_ZERO, SEED_LSB, SEED_A, SEED_B};
  logic [12:0]    bist_tab [4] = '{BIST_C0, BIST_C1, BIST_C2, BIST_C3};
  smlc_mod_ctrl_s mod_ctrl, em;
  smlc_ld_ctrl_s  ld_ctrl, el;
  int             failures, n_tests, n_sen;

  smlc_lock_ctrl u_dut (.core_clk, .reset_n, .spi_sen, .spi_sck, .spi_sdi, .spi_sdo,
    .spi_sdo_oe, .vco_sen, .vco_sclk, .vco_sdat, .vco_xfer_done, .cal_valid, .cal_data,
    .int_write_evt, .frac_write_evt, .cal_start, .seed_load, .modulator_seed, .mod_ctrl,
    .ld_sample, .ld_inside, .ld_locked, .relock_req, .ld_ctrl);
  smlc_host u_host (.core_clk, .spi_sen, .spi_sck, .spi_sdi, .spi_sdo, .spi_sdo_oe);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [23:0] wd);
    logic [23:0] x;
    u_host.xfer(1'b0, a, wd, 4, x);
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [23:0] e, input string nm);
    u_host.xfer(1'b1, a, 24'h000000, 6, rd);
    chk(nm, e, rd);
  endtask : rdchk

  task automatic pulse(input int k);
    @(posedge core_clk);
    frac_write_evt <= (k == 0);
    int_write_evt  <= (k == 1);
    cal_valid      <= (k == 2);
    @(posedge core_clk);
    {frac_write_evt, int_write_evt, cal_valid} <= 3'h0;
    repeat (3) @(posedge core_clk);
  endtask : pulse

  task automatic ld(input int n, input logic ins);
    repeat (n) begin
      @(posedge core_clk);
      ld_sample <= 1'b1;
      ld_inside <= ins;
      @(posedge core_clk);
      ld_sample <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
  endtask : ld

  task automatic final_report();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Collects the subsystem word and matches pulses against the oldest note.
  always @(posedge core_clk) begin
    if (vco_sclk && !sclk_q) sh = {sh[14:0], vco_sdat};
    sclk_q = vco_sclk;
    if (vco_sen) n_sen++;
    if (vco_xfer_done) begin
      d = q_x.size() ? q_x.pop_front() : 24'hFFFFFF;
      chk("vco_word", d, {8'h00, sh});
      chk("vco_sen_cycles", 24'(2 * VCO_WORD_W), 24'(n_sen));
      n_sen = 0;
    end
    if (seed_load) chk("seed", q_s.size() ? q_s.pop_front() : 24'hFFFFFF, modulator_seed);
    if (cal_start) chk("cal_start", q_c.size() ? q_c.pop_front() : 24'h0, 24'h1);
    if (relock_req) chk("relock_req", q_r.size() ? q_r.pop_front() : 24'h0, 24'h1);
  end

  initial begin
    void'($urandom(32'h3F4F2243));
    reset_n = 1'b0;
    {cal_valid, int_write_evt, frac_write_evt, ld_sample, ld_inside} = 5'h00;
    cal_data = 9'h000;
    sclk_q = 1'b0;
    sh = 16'h0000;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdchk(ADDR_VCO, {8'h00, RST_VCO}, "reg_vco");
    rdchk(ADDR_MOD, RST_MOD, "reg_mod");
    rdchk(ADDR_LD, RST_LD, "reg_ld");
    wr(6'h08, 24'hFFFFFF);
    rdchk(6'h08, 24'h000000, "unmapped");
    for (int i = 0; i < 8; i++) begin
      d = 24'($urandom());
      d[3:2] = i[1:0];
      d[20:19] = i[1:0];
      {d[21], d[10], d[9]} = i[2:0];
      wr(ADDR_MOD, d);
      rdchk(ADDR_MOD, d, "reg_mod");
      em.order = smlc_order_e'(d[3:2]);
      em.bypass = d[7];
      em.core_enable = d[11];
      em.clk_src = d[10] ? SRC_VCO_DLY : d[21] ? SRC_AUX : d[9] ? SRC_VCO_DIV : SRC_REF_DIV;
      em.bist_enable = d[18];
      em.bist_cycles = bist_tab[d[20:19]];
      chk("mod_ctrl", {4'h0, em}, {4'h0, mod_ctrl});
      d = 24'($urandom());
      d[9:7] = i[2:0];
      d[6] = (i != 5);
      wr(ADDR_LD, d);
      rdchk(ADDR_LD, d, "reg_ld");
      el.window_digital = d[6];
      el.window_half_cycles = !d[6] ? 8'h02 : (i == 0) ? 8'h01 : 8'(1 << i);
      el.timer_speed = d[11:10];
      el.timer_continuous = d[12];
      chk("ld_ctrl", {12'h000, el}, {12'h000, ld_ctrl});
    end
    for (int i = 0; i < 2; i++) begin
      v = 16'($urandom());
      v[2:0] = 3'h0;
      q_x.push_back({8'h00, v});
      wr(ADDR_VCO, {8'hA5, v});
      rdchk(ADDR_VCO, {8'h00, v}, "reg_vco");
      dv = 24'($urandom());
      cal_data <= dv[8:0];
      q_x.push_back({8'h00, dv[8:0], v[6:0]});
      pulse(2);
      rdchk(ADDR_VCO, {8'h00, dv[8:0], v[6:0]}, "reg_vco_cal");
    end
    for (int k = 0; k < 4; k++) begin
      d = RST_MOD;
      d[1:0] = k[1:0];
      d[MOD_RELOAD_SEED_ON_FREQ_WRITE] = 1'b1;
      d[MOD_CORE_EN] = 1'b1;
      wr(ADDR_MOD, d);
      q_s.push_back(seeds[k]);
      q_c.push_back(24'h1);
      pulse(0);
      pulse(1);
    end
    d[MOD_RELOAD_SEED_ON_FREQ_WRITE] = 1'b0;
    wr(ADDR_MOD, d);
    q_c.push_back(24'h1);
    pulse(0);
    d[MOD_CORE_EN] = 1'b0;
    wr(ADDR_MOD, d);
    q_c.push_back(24'h1);
    pulse(1);
    pulse(0);
    wr(ADDR_LD, 24'h002148);
    ld(4, 1'b1);
    chk("locked_early", 24'h0, {23'h0, ld_locked});
    ld(1, 1'b1);
    chk("locked", 24'h1, {23'h0, ld_locked});
    q_r.push_back(24'h1);
    ld(1, 1'b0);
    chk("unlocked", 24'h0, {23'h0, ld_locked});
    ld(1, 1'b0);
    wr(ADDR_LD, 24'h000148);
    ld(5, 1'b1);
    ld(1, 1'b0);
    wr(ADDR_LD, 24'h000140);
    ld(5, 1'b1);
    chk("locked_disabled", 24'h0, {23'h0, ld_locked});
    for (int t = 0; t < 300 && (q_x.size() + q_s.size() + q_c.size() + q_r.size()) > 0; t++)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    if ((q_x.size() + q_s.size() + q_c.size() + q_r.size()) > 0) begin
      failures++;
      $display("MISMATCH pending expected 0 seen %0d",
               q_x.size() + q_s.size() + q_c.size() + q_r.size());
    end
    final_report();
  end
endmodule : tb
